// ===== common/p3d_cfg.svh
// Address map, field masks and reset values of the port 3 data block.
// Assumes byte addresses on a 32-bit register port.
`ifndef P3D_CFG_SVH
`define P3D_CFG_SVH

`define P3D_ADDR_IE 32'h400200CC
`define P3D_ADDR_IN 32'h400200D0
`define P3D_ADDR_OUT 32'h400200D4
`define P3D_ADDR_SET 32'h400200D8
`define P3D_ADDR_CLEAR 32'h400200DC
`define P3D_ADDR_INV 32'h400200E0

// Pins 0, 1, 2 and 4 exist; bit 3 and bits 7..5 are reserved
`define P3D_PIN_MASK 8'h17
`define P3D_OUT_RESET 8'h00
`define P3D_IE_RESET 8'h17
`define P3D_IE_RSVD_ONES 8'hE8
`define P3D_BYTE_ZERO 8'h00
`define P3D_UPPER_ZERO 24'h000000
`define P3D_SYNC_RESET 1'b0

`endif

// ===== common/p3d_pkg.sv
// Types shared by the port 3 data block.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package p3d_pkg;

    typedef logic [7:0] p3d_byte_t;

    // Which register an access selects
    typedef enum logic [2:0] {
        P3D_SEL_NONE = 3'b000,
        P3D_SEL_IN = 3'b001,
        P3D_SEL_OUT = 3'b010,
        P3D_SEL_SET = 3'b011,
        P3D_SEL_CLEAR = 3'b100,
        P3D_SEL_INV = 3'b101,
        P3D_SEL_IE = 3'b110
    } p3d_sel_t;

endpackage

`default_nettype wire

// ===== hw/p3d_pin_sync.sv
// Two-flop synchroniser for the port pin levels.
// Assumes the pins are asynchronous to clk.
`include "p3d_cfg.svh"
`default_nettype none

module p3d_pin_sync #(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;

    // The first stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= {WIDTH{`P3D_SYNC_RESET}};
            sync_out <= {WIDTH{`P3D_SYNC_RESET}};
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule // p3d_pin_sync

`default_nettype wire

// ===== hw/p3d_port3_data.sv
// Port 3 data registers: pin input, output latch, set, clear, invert.
// Assumes a single-cycle register port on clk and pins asynchronous to clk.
//
// What this block does
// - Read-only input register shows sampled pin levels
// - Input shown only while path enabled, reset one
// - Read/write output latch, reset zero, drives pins
// - Set register writes ones into latch bits
// - Clear register writes zeros into latch bits
// - Invert register flips selected latch bits
// - Zero bits in set/clear/invert change nothing
// - Only bits 0, 1, 2, 4 reach pins
`include "p3d_cfg.svh"
`default_nettype none

module p3d_port3_data (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [31:0] bus_addr,
    input wire logic [31:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [31:0] bus_rdata,
    input wire logic [7:0] port3_pin_in,
    output logic [7:0] port3_pin_out
);

    localparam p3d_pkg::p3d_byte_t PIN_MASK = `P3D_PIN_MASK;

    ////////////////////////////////////////////////////////////////////////
    // Address decode

    function automatic p3d_pkg::p3d_sel_t p3d_decode(
        input logic [31:0] addr
    );
        p3d_pkg::p3d_sel_t sel;
        sel = p3d_pkg::P3D_SEL_NONE;
        case (addr)
            `P3D_ADDR_IN: sel = p3d_pkg::P3D_SEL_IN;
            `P3D_ADDR_OUT: sel = p3d_pkg::P3D_SEL_OUT;
            `P3D_ADDR_SET: sel = p3d_pkg::P3D_SEL_SET;
            `P3D_ADDR_CLEAR: sel = p3d_pkg::P3D_SEL_CLEAR;
            `P3D_ADDR_INV: sel = p3d_pkg::P3D_SEL_INV;
            `P3D_ADDR_IE: sel = p3d_pkg::P3D_SEL_IE;
            default: sel = p3d_pkg::P3D_SEL_NONE;
        endcase
        return sel;
    endfunction

    p3d_pkg::p3d_sel_t wr_sel;
    p3d_pkg::p3d_sel_t rd_sel;
    p3d_pkg::p3d_byte_t wr_byte;
    logic wr_out;
    logic wr_set;
    logic wr_clear;
    logic wr_inv;
    logic wr_ie;

    assign wr_sel = bus_wr ? p3d_decode(bus_addr) : p3d_pkg::P3D_SEL_NONE;
    assign rd_sel = bus_rd ? p3d_decode(bus_addr) : p3d_pkg::P3D_SEL_NONE;
    // Reserved bits of a write are dropped here so they never reach a pin
    assign wr_byte = bus_wdata[7:0] & PIN_MASK;
    assign wr_out = (wr_sel == p3d_pkg::P3D_SEL_OUT);
    assign wr_set = (wr_sel == p3d_pkg::P3D_SEL_SET);
    assign wr_clear = (wr_sel == p3d_pkg::P3D_SEL_CLEAR);
    assign wr_inv = (wr_sel == p3d_pkg::P3D_SEL_INV);
    assign wr_ie = (wr_sel == p3d_pkg::P3D_SEL_IE);

    ////////////////////////////////////////////////////////////////////////
    // Pin input path

    p3d_pkg::p3d_byte_t pin_sync;
    p3d_pkg::p3d_byte_t in_reg;
    p3d_pkg::p3d_byte_t in_next;
    p3d_pkg::p3d_byte_t ie_reg;
    p3d_pkg::p3d_byte_t ie_next;

    p3d_pin_sync #(
        .WIDTH(8)
    ) u_pin_sync (
        .clk(clk),
        .rst_n(rst_n),
        .async_in(port3_pin_in),
        .sync_out(pin_sync)
    );

    assign ie_next = wr_ie ? wr_byte : ie_reg;
    // A disabled path reads low rather than floating
    assign in_next = pin_sync & ie_reg & PIN_MASK;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ie_reg <= `P3D_IE_RESET;
            in_reg <= `P3D_BYTE_ZERO;
        end else begin
            ie_reg <= ie_next;
            in_reg <= in_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output latch

    p3d_pkg::p3d_byte_t latch_reg;
    p3d_pkg::p3d_byte_t latch_next;

    // Only one register is addressed per cycle, so the branches never race
    for (genvar b = 0; b < 8; b++) begin : g_latch_bit
        assign latch_next[b] =
            !PIN_MASK[b] ? 1'b0 :
            wr_out ? wr_byte[b] :
            (wr_set && wr_byte[b]) ? 1'b1 :
            (wr_clear && wr_byte[b]) ? 1'b0 :
            (wr_inv && wr_byte[b]) ? !latch_reg[b] :
            latch_reg[b];
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            latch_reg <= `P3D_OUT_RESET;
        end else begin
            latch_reg <= latch_next;
        end
    end

    assign port3_pin_out = latch_reg;

    ////////////////////////////////////////////////////////////////////////
    // Read data

    p3d_pkg::p3d_byte_t rd_byte;
    logic [31:0] rdata_next;

    // Write-only strobes and unmapped addresses fall through to zero
    assign rd_byte =
        (rd_sel == p3d_pkg::P3D_SEL_IN) ? in_reg :
        (rd_sel == p3d_pkg::P3D_SEL_OUT) ? latch_reg :
        (rd_sel == p3d_pkg::P3D_SEL_IE) ? (ie_reg | `P3D_IE_RSVD_ONES) :
        `P3D_BYTE_ZERO;
    assign rdata_next = {`P3D_UPPER_ZERO, rd_byte};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_rdata <= {`P3D_UPPER_ZERO, `P3D_BYTE_ZERO};
        end else begin
            bus_rdata <= rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    function automatic logic p3d_hit(
        input logic [31:0] addr,
        input logic [31:0] target
    );
        return addr == target;
    endfunction

    property p_in_follows_pins;
        1 |=> in_reg == ($past(pin_sync) & $past(ie_reg) & PIN_MASK);
    endproperty
    a_in_follows_pins: assert property (p_in_follows_pins)
        else $error("input register does not follow synced pins");

    property p_in_gated;
        1 |=> (in_reg & ~$past(ie_reg)) == `P3D_BYTE_ZERO;
    endproperty
    a_in_gated: assert property (p_in_gated)
        else $error("disabled input path shows a level");

    property p_in_read;
        bus_rd && p3d_hit(bus_addr, `P3D_ADDR_IN)
            |=> bus_rdata == {`P3D_UPPER_ZERO, $past(in_reg)};
    endproperty
    a_in_read: assert property (p_in_read)
        else $error("input read returns wrong value");

    property p_out_write;
        bus_wr && p3d_hit(bus_addr, `P3D_ADDR_OUT)
            |=> port3_pin_out == ($past(bus_wdata[7:0]) & PIN_MASK);
    endproperty
    a_out_write: assert property (p_out_write)
        else $error("output write not reflected on pins");

    property p_set;
        bus_wr && p3d_hit(bus_addr, `P3D_ADDR_SET)
            |=> latch_reg == ($past(latch_reg)
                | ($past(bus_wdata[7:0]) & PIN_MASK));
    endproperty
    a_set: assert property (p_set)
        else $error("set write wrong");

    property p_clear;
        bus_wr && p3d_hit(bus_addr, `P3D_ADDR_CLEAR)
            |=> latch_reg == ($past(latch_reg) & ~$past(bus_wdata[7:0]));
    endproperty
    a_clear: assert property (p_clear)
        else $error("clear write wrong");

    property p_inv;
        bus_wr && p3d_hit(bus_addr, `P3D_ADDR_INV)
            |=> latch_reg == ($past(latch_reg)
                ^ ($past(bus_wdata[7:0]) & PIN_MASK));
    endproperty
    a_inv: assert property (p_inv)
        else $error("invert write wrong");

    property p_zero_no_effect;
        bus_wr && (bus_wdata[7:0] == `P3D_BYTE_ZERO)
            && (wr_set || wr_clear || wr_inv) |=> $stable(latch_reg);
    endproperty
    a_zero_no_effect: assert property (p_zero_no_effect)
        else $error("zero strobe write changed the latch");

    property p_reserved_quiet;
        (port3_pin_out & ~PIN_MASK) == `P3D_BYTE_ZERO;
    endproperty
    a_reserved_quiet: assert property (p_reserved_quiet)
        else $error("reserved pin bit driven");

    property p_wo_read;
        bus_rd && (rd_sel inside {p3d_pkg::P3D_SEL_SET,
            p3d_pkg::P3D_SEL_CLEAR, p3d_pkg::P3D_SEL_INV})
            |=> bus_rdata == {`P3D_UPPER_ZERO, `P3D_BYTE_ZERO}
                && $stable(latch_reg);
    endproperty
    a_wo_read: assert property (p_wo_read)
        else $error("write-only read not zero or had side effect");

    property p_idle_rdata;
        !bus_rd |=> bus_rdata == {`P3D_UPPER_ZERO, `P3D_BYTE_ZERO};
    endproperty
    a_idle_rdata: assert property (p_idle_rdata)
        else $error("read data not zero outside read answer");

    // The bench leaves one idle cycle between accesses, hence the gaps
    c_set: cover property (wr_set ##2 wr_clear);
    c_inv_twice: cover property (wr_inv ##2 wr_inv);
    c_ie_off_read: cover property (wr_ie ##[1:12]
        (rd_sel == p3d_pkg::P3D_SEL_IN));
    c_pin_change: cover property ($changed(in_reg));

endmodule // p3d_port3_data

`default_nettype wire

// ===== dv/p3d_pin_model.sv
// Model of the circuitry hung on the port 3 pins.
// Assumes the bench chooses between an outside level and a loopback.
`default_nettype none

module p3d_pin_model (
    input wire logic [7:0] pin_drive,
    input wire logic [7:0] ext_level,
    input wire logic loop_en,
    output logic [7:0] pin_level
);
    timeunit 1ns;
    timeprecision 1ns;

    // Loopback is a pin wired to itself, so it reads back what is driven
    assign pin_level = loop_en ? pin_drive : ext_level;
endmodule // p3d_pin_model

`default_nettype wire

// ===== dv/tb_p3d_port3_data.sv
// Self-checking bench for the port 3 data registers.
// Assumes read data stand only in the cycle after the read strobe.
`include "p3d_cfg.svh"
`default_nettype none

module tb_p3d_port3_data;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk, rst_n, bus_wr, bus_rd, loop_en;
    logic [31:0] bus_addr, bus_wdata, bus_rdata;
    logic [7:0] pin_in, pin_out, ext_level;
    int n_fail, checked;

    p3d_port3_data uut (.clk(clk), .rst_n(rst_n), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_rdata(bus_rdata), .port3_pin_in(pin_in),
        .port3_pin_out(pin_out));

    p3d_pin_model pins (.pin_drive(pin_out), .ext_level(ext_level),
        .loop_en(loop_en), .pin_level(pin_in));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Only word addresses are used; the bit alias space is never touched
    task automatic wr(input logic [31:0] a, d);
        @(posedge clk);
        bus_wr <= 1'b1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge clk);
        bus_wr <= 1'b0;
        #1;
    endtask

    // Write, then look at the pin drive once the write edge has landed
    task automatic wp(input logic [31:0] a, d, input logic [7:0] e);
        wr(a, d);
        chk("pin drive", {24'h000000, pin_out}, {24'h000000, e});
    endtask

    task automatic rd(input logic [31:0] a, exp);
        @(posedge clk);
        bus_rd <= 1'b1;
        bus_addr <= a;
        @(posedge clk);
        bus_rd <= 1'b0;
        #1;
        chk("read data", bus_rdata, exp);
    endtask

    // Two sync flops plus the input register need three edges; allow four
    task automatic drive_pins(input logic [7:0] lvl);
        @(posedge clk);
        ext_level <= lvl;
        repeat (4) @(posedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'b0;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        bus_addr = 32'h00000000;
        bus_wdata = 32'h00000000;
        loop_en = 1'b0;
        ext_level = 8'h00;
        n_fail = 0;
        checked = 0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rd(`P3D_ADDR_OUT, 32'h00000000);
        chk("pin drive", {24'h000000, pin_out}, 32'h00000000);
        rd(`P3D_ADDR_IE, 32'h000000FF);
        wp(`P3D_ADDR_OUT, 32'hFFFFFFFF, 8'h17);
        rd(`P3D_ADDR_OUT, 32'h00000017);
        wp(`P3D_ADDR_OUT, 32'h00000000, 8'h00);
        wp(`P3D_ADDR_SET, 32'h00000005, 8'h05);
        wp(`P3D_ADDR_SET, 32'h00000010, 8'h15);
        wp(`P3D_ADDR_CLEAR, 32'h00000001, 8'h14);
        wp(`P3D_ADDR_INV, 32'h00000012, 8'h06);
        wp(`P3D_ADDR_INV, 32'h000000E8, 8'h06);
        wp(`P3D_ADDR_SET, 32'h000000E8, 8'h06);
        wp(`P3D_ADDR_CLEAR, 32'h00000000, 8'h06);
        wp(`P3D_ADDR_INV, 32'h00000004, 8'h02);
        wp(`P3D_ADDR_INV, 32'h00000004, 8'h06);
        rd(`P3D_ADDR_SET, 32'h00000000);
        rd(`P3D_ADDR_CLEAR, 32'h00000000);
        rd(`P3D_ADDR_INV, 32'h00000000);
        chk("pin drive", {24'h000000, pin_out}, 32'h00000006);
        rd(32'h400200E8, 32'h00000000);
        wp(32'h400200E8, 32'h000000FF, 8'h06);
        drive_pins(8'hFF);
        rd(`P3D_ADDR_IN, 32'h00000017);
        drive_pins(8'h0A);
        rd(`P3D_ADDR_IN, 32'h00000002);
        wr(`P3D_ADDR_IE, 32'h00000001);
        drive_pins(8'hFF);
        rd(`P3D_ADDR_IN, 32'h00000001);
        wr(`P3D_ADDR_IE, 32'h00000017);
        @(posedge clk) loop_en <= 1'b1;
        wr(`P3D_ADDR_OUT, 32'h00000014);
        repeat (4) @(posedge clk);
        rd(`P3D_ADDR_IN, 32'h00000014);
        // Mid-run reset must bring back the latch and enable defaults
        @(posedge clk) rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd(`P3D_ADDR_OUT, 32'h00000000);
        rd(`P3D_ADDR_IE, 32'h000000FF);
        final_report();
    end

    // The tests need some 100 cycles; 2000 means something hangs
    initial begin
        #(2000 * 100);
        n_fail++;
        final_report();
    end
endmodule // tb_p3d_port3_data

`default_nettype wire
